// ### hw/mmbd_cfg.svh
/*
 * Constants of the memory map and bank decode: page layout, reset values
 * of the page, boundary and space-control registers, space indices.
 * Assumes it is included by bare name by the decoder.
 */
`ifndef MMBD_CFG_SVH
`define MMBD_CFG_SVH

// ----------------------------------------------------------------------
// Map layout
// ----------------------------------------------------------------------
`define MMBD_PAGE_ZERO 8'h00
`define MMBD_PAGE_LAST 8'hFF
`define MMBD_BANK_LAST_PAGE 8'hFE
`define MMBD_ROM_WORD_TOP 6'h3F
`define MMBD_IO_INT_PAGES 8'h20
`define MMBD_PC_RESET 24'hFFFC00

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define MMBD_BOUND1_RST 8'h40
`define MMBD_BOUND2_RST 8'h80
`define MMBD_BOUND3_RST 8'hC0
`define MMBD_PAGE_RST 8'h00
`define MMBD_CTRL_RST 16'hFC04
`define MMBD_STROBE_IDLE 1'b1

// ----------------------------------------------------------------------
// Off-chip space indices
// ----------------------------------------------------------------------
`define MMBD_SPACES 6
`define MMBD_SP_IO 3'h4
`define MMBD_SP_BOOT 3'h5

`endif

// ### hw/mmbd_pkg.sv
/*
 * Types of the memory map and bank decode: request kinds, sequencer
 * operations, decode targets, register selects and the carried structs.
 * Assumes mmbd_cfg.svh is on the include path.
 */
package mmbd_pkg;
	typedef enum logic [1:0] {MMBD_K_FETCH, MMBD_K_DATA, MMBD_K_IO, MMBD_K_BOOT} mmbd_kind_e;
	typedef enum logic [1:0] {MMBD_SEQ_NEXT, MMBD_SEQ_REL, MMBD_SEQ_DIRECT,
		MMBD_SEQ_INDIRECT} mmbd_seq_e;
	typedef enum logic [2:0] {MMBD_T_NONE, MMBD_T_RAM0, MMBD_T_RAM1, MMBD_T_ROM, MMBD_T_BANK,
		MMBD_T_IO_INT, MMBD_T_IO_EXT, MMBD_T_BOOT} mmbd_target_e;
	typedef enum logic [2:0] {MMBD_CFG_DPAGE0, MMBD_CFG_DPAGE1, MMBD_CFG_JPAGE, MMBD_CFG_IOPAGE,
		MMBD_CFG_BOUND1, MMBD_CFG_BOUND2, MMBD_CFG_BOUND3, MMBD_CFG_CTRL} mmbd_cfg_sel_e;

	typedef struct packed {
		logic [2:0] rd_wait;
		logic [2:0] wr_wait;
		logic [1:0] wait_mode;
		logic [2:0] clk_div;
		logic hold_ext;
		logic strobe_pol;
		logic width16;
		logic [1:0] spare;
	} mmbd_space_ctrl_s;

	typedef struct packed {
		logic valid;
		mmbd_kind_e kind;
		logic address_generator;
		logic write;
		logic [15:0] ptr;
		logic [9:0] imm10;
		logic [15:0] wdata;
		mmbd_seq_e seq_op;
		logic [15:0] seq_offset;
		logic [23:0] seq_target;
	} mmbd_core_req_s;

	typedef struct packed {
		logic valid;
		logic boot;
		logic write;
		logic [23:0] addr;
		logic [15:0] wdata;
	} mmbd_dma_req_s;

	typedef struct packed {
		logic [21:0] addr;
		logic [3:0] bank_select_n;
		logic io_space_select_n;
		logic boot_space_select_n;
		logic rd_strobe;
		logic wr_strobe;
		mmbd_space_ctrl_s ctrl;
	} mmbd_ext_port_s;
endpackage

// ### hw/mmbd_decode.sv
/*
 * Address formation and memory-map decode. Builds 24-bit addresses from
 * page registers and pointers, routes core and DMA accesses to on-chip
 * RAM, boot ROM, external banks, I/O or boot space, and drives the
 * external port selects, strobes and data lines for one cycle per access.
 * Assumes requests and pins are synchronous to clk_sys; wait-state timing
 * is done elsewhere from the space-control fields presented on the port.
 */
`include "mmbd_cfg.svh"

module mmbd_decode (
	input wire logic clk_sys, // 125 MHz system clock
	input wire logic rst, // Synchronous reset, active high
	input wire mmbd_pkg::mmbd_core_req_s core_req, // Core access request
	output logic core_ready, // Core request taken this cycle
	input wire mmbd_pkg::mmbd_dma_req_s dma_req, // DMA peripheral request
	output logic dma_ready, // DMA request taken this cycle
	input wire logic cfg_we, // Register write strobe
	input wire mmbd_pkg::mmbd_cfg_sel_e cfg_sel, // Register selected for write
	input wire logic [2:0] cfg_space, // Space index for control writes
	input wire logic [15:0] cfg_wdata, // Register write data
	output logic [23:0] prog_counter, // Current fetch address
	output logic acc_valid, // Decoded access pulse
	output mmbd_pkg::mmbd_target_e acc_target, // Target of decoded access
	output logic [23:0] acc_addr, // Full address of decoded access
	output logic acc_write, // Decoded access is a write
	output mmbd_pkg::mmbd_ext_port_s ext, // External port address and controls
	output logic [15:0] ext_data_out, // External data lines, out
	output logic ext_data_oe_lo, // Drive enable, low data byte
	output logic ext_data_oe_hi, // Drive enable, upper lines
	input wire logic [15:0] ext_data_in, // External data lines, in
	input wire logic [7:0] gpio_out, // GPIO value for upper lines
	input wire logic [7:0] gpio_oe, // GPIO drive enables
	output logic [7:0] gpio_in, // Sampled upper lines in GPIO mode
	output logic rd_valid, // External read data pulse
	output logic [15:0] rd_data // External read data
);
	import mmbd_pkg::*;

	// ------------------------------------------------------------------
	// Page, boundary and space-control registers
	// ------------------------------------------------------------------
	logic [7:0] data_page_reg [0:1];
	logic [7:0] jump_page_reg;
	logic [7:0] io_page_reg;
	logic [7:0] bound1;
	logic [7:0] bound2;
	logic [7:0] bound3;
	mmbd_space_ctrl_s space_ctrl [0:`MMBD_SPACES-1];
	logic [`MMBD_SPACES-1:0] narrow;

	// State of the access on the port
	logic sel_active;
	logic acc_read_ext;
	logic hi_gpio_mode;

	// ------------------------------------------------------------------
	// Arbitration
	// ------------------------------------------------------------------
	// Core wins over DMA; a cycle with selects asserted is always
	// followed by a released cycle so no two accesses merge.
	wire port_free = !sel_active;
	wire core_go = core_req.valid && port_free;
	wire dma_go = dma_req.valid && port_free && !core_req.valid;
	wire go = core_go || dma_go;

	assign core_ready = port_free;
	assign dma_ready = port_free && !core_req.valid;

	// ------------------------------------------------------------------
	// Address formation
	// ------------------------------------------------------------------
	wire [23:0] data_addr = {data_page_reg[core_req.address_generator], core_req.ptr};
	wire [17:0] io_addr = {io_page_reg, core_req.imm10};
	wire [23:0] io_addr_wide = {6'h00, io_addr};
	wire core_is_fetch = core_req.kind == MMBD_K_FETCH;
	wire core_is_io = core_req.kind == MMBD_K_IO;

	wire [23:0] core_addr = core_is_fetch ? prog_counter :
		core_is_io ? io_addr_wide : data_addr;
	wire [23:0] req_addr = core_go ? core_addr : dma_req.addr;
	// DMA never issues fetch or I/O kinds
	wire mmbd_kind_e req_kind = core_go ? core_req.kind :
		(dma_req.boot ? MMBD_K_BOOT : MMBD_K_DATA);
	wire req_write = core_go ? (core_req.write && !core_is_fetch) : dma_req.write;
	wire [15:0] req_wdata = core_go ? core_req.wdata : dma_req.wdata;

	// ------------------------------------------------------------------
	// Sequencer next address
	// ------------------------------------------------------------------
	wire [23:0] rel_offset = {{8{core_req.seq_offset[15]}}, core_req.seq_offset};
	wire [23:0] pc_step = prog_counter + 24'h000001;
	wire [23:0] pc_rel = prog_counter + rel_offset;
	wire [23:0] pc_indirect = {jump_page_reg, core_req.ptr};
	logic [23:0] next_pc;

	// Branch offsets are signed and wrap within the 24-bit space
	always_comb begin
		case (core_req.seq_op)
			MMBD_SEQ_NEXT: next_pc = pc_step;
			MMBD_SEQ_REL: next_pc = pc_rel;
			MMBD_SEQ_DIRECT: next_pc = core_req.seq_target;
			MMBD_SEQ_INDIRECT: next_pc = pc_indirect;
			default: next_pc = pc_step;
		endcase
	end

	// ------------------------------------------------------------------
	// Memory map decode
	// ------------------------------------------------------------------
	wire [7:0] page = req_addr[23:16];
	wire is_page0 = page == `MMBD_PAGE_ZERO;
	wire is_rom = (page == `MMBD_PAGE_LAST) && (req_addr[15:10] == `MMBD_ROM_WORD_TOP);
	// Rest of page 255 below the ROM is left unmapped
	wire is_ext_page = !is_page0 && (page <= `MMBD_BANK_LAST_PAGE);

	// Boundaries are compared as written; software keeps them ascending
	wire [1:0] bank_idx = (page >= bound3) ? 2'h3 :
		(page >= bound2) ? 2'h2 :
		(page >= bound1) ? 2'h1 : 2'h0;

	// Only the low 18 bits carry an I/O address
	wire [17:0] req_io_addr = req_addr[17:0];
	wire req_io_internal = req_io_addr[17:10] < `MMBD_IO_INT_PAGES;

	wire mmbd_target_e mem_target = is_page0 ? (req_addr[15] ? MMBD_T_RAM1 : MMBD_T_RAM0) :
		is_rom ? MMBD_T_ROM :
		is_ext_page ? MMBD_T_BANK : MMBD_T_NONE;
	wire mmbd_target_e io_target = req_io_internal ? MMBD_T_IO_INT : MMBD_T_IO_EXT;
	wire mmbd_target_e next_target = (req_kind == MMBD_K_IO) ? io_target :
		(req_kind == MMBD_K_BOOT) ? MMBD_T_BOOT : mem_target;

	wire tgt_bank = next_target == MMBD_T_BANK;
	wire tgt_io_ext = next_target == MMBD_T_IO_EXT;
	wire tgt_boot = next_target == MMBD_T_BOOT;
	// Page zero and the ROM never reach the port
	wire next_ext = tgt_bank || tgt_io_ext || tgt_boot;
	wire ext_go = go && next_ext;

	// Control word follows the space that owns the access
	wire [2:0] next_space = tgt_io_ext ? `MMBD_SP_IO :
		tgt_boot ? `MMBD_SP_BOOT : {1'b0, bank_idx};
	wire mmbd_space_ctrl_s sel_ctrl = space_ctrl[next_space];

	// ------------------------------------------------------------------
	// Select and strobe formation
	// ------------------------------------------------------------------
	wire [3:0] bank_onehot = 4'h1 << bank_idx;
	wire [3:0] next_bank_sel_n = (ext_go && tgt_bank) ? ~bank_onehot : 4'hF;
	wire next_io_sel_n = !(ext_go && tgt_io_ext);
	wire next_boot_sel_n = !(ext_go && tgt_boot);
	wire rd_active = ext_go && !req_write;
	wire wr_active = ext_go && req_write;
	// Polarity bit set means strobes are active high
	wire next_rd_strobe = !(rd_active ^ sel_ctrl.strobe_pol);
	wire next_wr_strobe = !(wr_active ^ sel_ctrl.strobe_pol);
	// Port carries 22 address bits; I/O addresses arrive zero-extended
	wire [21:0] next_ext_addr = req_addr[21:0];

	// ------------------------------------------------------------------
	// Upper data line ownership
	// ------------------------------------------------------------------
	// Space indices 6 and 7 match no entry and are dropped
	genvar gi;
	generate
		for (gi = 0; gi < `MMBD_SPACES; gi++) begin : g_space
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					space_ctrl[gi] <= mmbd_space_ctrl_s'(`MMBD_CTRL_RST);
				end else if (cfg_we && cfg_sel == MMBD_CFG_CTRL && cfg_space == 3'(gi)) begin
					space_ctrl[gi] <= mmbd_space_ctrl_s'(cfg_wdata);
				end
			end
			assign narrow[gi] = !space_ctrl[gi].width16;
		end
	endgenerate

	// Between accesses the upper lines are GPIO only when no space
	// uses the wide port; a mixed setup keeps them as data lines.
	wire all_narrow = &narrow;
	wire next_hi_gpio = ext_go ? !sel_ctrl.width16 : all_narrow;
	wire [7:0] next_hi_out = next_hi_gpio ? gpio_out : req_wdata[15:8];
	wire [7:0] next_hi_oe = next_hi_gpio ? gpio_oe : {8{wr_active}};
	wire next_oe_hi = |next_hi_oe;
	wire [15:0] next_rd_data = ext.ctrl.width16 ? ext_data_in : {8'h00, ext_data_in[7:0]};

	// ------------------------------------------------------------------
	// Page and boundary registers
	// ------------------------------------------------------------------
	wire wr_dpage0 = cfg_we && cfg_sel == MMBD_CFG_DPAGE0;
	wire wr_dpage1 = cfg_we && cfg_sel == MMBD_CFG_DPAGE1;
	wire wr_jpage = cfg_we && cfg_sel == MMBD_CFG_JPAGE;
	wire wr_iopage = cfg_we && cfg_sel == MMBD_CFG_IOPAGE;
	wire wr_bound1 = cfg_we && cfg_sel == MMBD_CFG_BOUND1;
	wire wr_bound2 = cfg_we && cfg_sel == MMBD_CFG_BOUND2;
	wire wr_bound3 = cfg_we && cfg_sel == MMBD_CFG_BOUND3;

	// Page and boundary registers keep only the low byte
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			data_page_reg[0] <= `MMBD_PAGE_RST;
			data_page_reg[1] <= `MMBD_PAGE_RST;
			jump_page_reg <= `MMBD_PAGE_RST;
			io_page_reg <= `MMBD_PAGE_RST;
		end else begin
			if (wr_dpage0) data_page_reg[0] <= cfg_wdata[7:0];
			if (wr_dpage1) data_page_reg[1] <= cfg_wdata[7:0];
			if (wr_jpage) jump_page_reg <= cfg_wdata[7:0];
			if (wr_iopage) io_page_reg <= cfg_wdata[7:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bound1 <= `MMBD_BOUND1_RST;
			bound2 <= `MMBD_BOUND2_RST;
			bound3 <= `MMBD_BOUND3_RST;
		end else begin
			if (wr_bound1) bound1 <= cfg_wdata[7:0];
			if (wr_bound2) bound2 <= cfg_wdata[7:0];
			if (wr_bound3) bound3 <= cfg_wdata[7:0];
		end
	end

	// ------------------------------------------------------------------
	// Program counter
	// ------------------------------------------------------------------
	// The boot configuration only steers what the ROM code does later,
	// so reset needs no strap here.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prog_counter <= `MMBD_PC_RESET;
		end else if (core_go && core_is_fetch) begin
			prog_counter <= next_pc;
		end
	end

	// ------------------------------------------------------------------
	// Decoded access report
	// ------------------------------------------------------------------
	// Report holds the last access until the next one
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			acc_valid <= 1'b0;
			acc_target <= MMBD_T_NONE;
			acc_addr <= 24'h000000;
			acc_write <= 1'b0;
		end else begin
			acc_valid <= go;
			if (go) begin
				acc_target <= next_target;
				acc_addr <= req_addr;
				acc_write <= req_write;
			end
		end
	end

	// ------------------------------------------------------------------
	// External port
	// ------------------------------------------------------------------
	// Selects are rebuilt every cycle, so one that is not re-armed by a
	// new access falls back to released on the next edge.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sel_active <= 1'b0;
			acc_read_ext <= 1'b0;
			ext.bank_select_n <= 4'hF;
			ext.io_space_select_n <= 1'b1;
			ext.boot_space_select_n <= 1'b1;
			ext.rd_strobe <= `MMBD_STROBE_IDLE;
			ext.wr_strobe <= `MMBD_STROBE_IDLE;
			ext.addr <= 22'h000000;
			ext.ctrl <= mmbd_space_ctrl_s'(`MMBD_CTRL_RST);
		end else begin
			sel_active <= ext_go;
			acc_read_ext <= rd_active;
			ext.bank_select_n <= next_bank_sel_n;
			ext.io_space_select_n <= next_io_sel_n;
			ext.boot_space_select_n <= next_boot_sel_n;
			ext.rd_strobe <= next_rd_strobe;
			ext.wr_strobe <= next_wr_strobe;
			// Address and controls hold between accesses for the wait logic
			if (ext_go) begin
				ext.addr <= next_ext_addr;
				ext.ctrl <= sel_ctrl;
			end
		end
	end

	// ------------------------------------------------------------------
	// Data lines and GPIO
	// ------------------------------------------------------------------
	// Write data loads every cycle; only the enables reach the pins
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ext_data_out <= 16'h0000;
			ext_data_oe_lo <= 1'b0;
			ext_data_oe_hi <= 1'b0;
			hi_gpio_mode <= 1'b0;
		end else begin
			ext_data_out[7:0] <= req_wdata[7:0];
			ext_data_out[15:8] <= next_hi_out;
			ext_data_oe_lo <= wr_active;
			ext_data_oe_hi <= next_oe_hi;
			hi_gpio_mode <= next_hi_gpio;
		end
	end

	// Narrow reads return zero in the upper byte
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			gpio_in <= 8'h00;
			rd_valid <= 1'b0;
			rd_data <= 16'h0000;
		end else begin
			if (hi_gpio_mode) gpio_in <= ext_data_in[15:8];
			rd_valid <= acc_read_ext;
			if (acc_read_ext) rd_data <= next_rd_data;
		end
	end
endmodule

// ### verification/mmbd_decode_properties.sv
/*
 * Checker for mmbd_decode: map decode, select lines, address forming.
 * Assumes it is bound to mmbd_decode and sees its ports, one clock.
 */
module mmbd_decode_properties (
	input wire logic clk_sys, // System clock
	input wire logic rst, // Sync reset
	input wire mmbd_pkg::mmbd_core_req_s core_req, // Core request
	input wire logic core_ready, // Core request taken
	input wire logic dma_ready, // DMA request taken
	input wire logic [23:0] prog_counter, // Fetch address
	input wire logic acc_valid, // Access pulse
	input wire mmbd_pkg::mmbd_target_e acc_target, // Access target
	input wire logic [23:0] acc_addr, // Access address
	input wire logic acc_write, // Access is a write
	input wire mmbd_pkg::mmbd_ext_port_s ext, // External port
	input wire logic rd_valid // Read data pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	import mmbd_pkg::*;
	wire [5:0] sel_n = {ext.bank_select_n, ext.io_space_select_n, ext.boot_space_select_n};
	wire any_sel = sel_n != 6'h3F;
	wire core_take = core_req.valid && core_ready;
	wire [7:0] io_pg = acc_addr[17:10];

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// ----------------------------------------
	// Access steps
	// ----------------------------------------
	sequence s_ext_read;
		acc_valid && !acc_write && any_sel;
	endsequence
	sequence s_fetch_next;
		core_take && core_req.kind == MMBD_K_FETCH && core_req.seq_op == MMBD_SEQ_NEXT;
	endsequence

	chk_one_select: assert property ($countones(~sel_n) <= 1)
		else $error("more than one select low");
	chk_select_release: assert property (any_sel |=> !any_sel)
		else $error("select held past one cycle");
	chk_select_cause: assert property (any_sel |->
		acc_valid && acc_target inside {MMBD_T_BANK, MMBD_T_IO_EXT, MMBD_T_BOOT})
		else $error("select without off-chip access");
	chk_ram_page: assert property (acc_valid &&
		acc_target inside {MMBD_T_RAM0, MMBD_T_RAM1}
		|-> acc_addr[23:16] == 8'h00 && (acc_target == MMBD_T_RAM1) == acc_addr[15])
		else $error("ram target outside page zero half");
	chk_rom_top: assert property (acc_valid && acc_target == MMBD_T_ROM
		|-> acc_addr[23:10] == 14'h3FFF)
		else $error("rom target outside top of last page");
	chk_bank_line: assert property (acc_valid && acc_target == MMBD_T_BANK
		|-> sel_n inside {6'h3B, 6'h37, 6'h2F, 6'h1F})
		else $error("bank access without one bank select");
	chk_io_select: assert property (acc_valid && acc_target == MMBD_T_IO_EXT
		|-> sel_n == 6'h3D && io_pg >= 8'h20)
		else $error("external io select wrong");
	chk_io_inside: assert property (acc_valid && acc_target == MMBD_T_IO_INT
		|-> !any_sel && io_pg < 8'h20)
		else $error("internal io page wrong");
	chk_boot_select: assert property (acc_valid && acc_target == MMBD_T_BOOT
		|-> sel_n == 6'h3E)
		else $error("boot access without boot select");
	chk_data_addr: assert property (core_take && core_req.kind == MMBD_K_DATA
		|=> acc_valid && acc_addr[15:0] == $past(core_req.ptr))
		else $error("data address low part wrong");
	chk_io_addr: assert property (core_take && core_req.kind == MMBD_K_IO
		|=> acc_addr[9:0] == $past(core_req.imm10) && acc_addr[23:18] == 6'h00)
		else $error("io address forming wrong");
	chk_pc_next: assert property (s_fetch_next
		|=> prog_counter == $past(prog_counter) + 24'h000001)
		else $error("fetch counter did not advance");
	chk_read_return: assert property (s_ext_read |=> rd_valid)
		else $error("read data pulse missing");
	chk_ext_addr: assert property (any_sel |-> ext.addr == acc_addr[21:0])
		else $error("port address differs");
	chk_reset_fetch: assert property ($fell(rst) |-> prog_counter == 24'hFFFC00)
		else $error("fetch does not start in rom");
	chk_core_first: assert property (core_req.valid |-> !dma_ready)
		else $error("dma offered while core waits");
endmodule

// ### verification/mmbd_ext_mem.sv
/*
 * Model of the memories and devices on the external port.
 * Assumes one select per access and data sampled at the cycle end.
 */
module mmbd_ext_mem (
	input wire logic clk_sys, // System clock
	input wire mmbd_pkg::mmbd_ext_port_s ext, // Port controls
	input wire logic [15:0] ext_data_out, // Write data
	output logic [15:0] ext_data_in // Read data
);
	timeunit 1ns;
	timeprecision 1ps;
	import mmbd_pkg::*;
	logic [15:0] mem [0:1023];
	logic [15:0] last = 16'h0000;
	// Each space keeps its own cells
	wire [9:0] idx = {~{ext.bank_select_n, ext.io_space_select_n, ext.boot_space_select_n},
		ext.addr[3:0]};
	wire on = idx[9:4] != 6'h00;
	wire rd = on && (ext.rd_strobe == ext.ctrl.strobe_pol);
	wire wr = on && (ext.wr_strobe == ext.ctrl.strobe_pol);
	always_ff @(posedge clk_sys) begin
		if (wr)
			mem[idx] <= ext_data_out;
		if (rd)
			last <= mem[idx];
	end
	// Released lines show no stale data
	assign ext_data_in = rd ? mem[idx] : ~last;
endmodule

// ### verification/testbench.sv
/*
 * Self-checking bench for mmbd_decode with the external memory model.
 * Assumes the checker and mmbd_cfg.svh are compiled alongside.
 */
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import mmbd_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	mmbd_core_req_s core_req = '0;
	mmbd_dma_req_s dma_req = '0;
	logic core_ready, dma_ready, acc_valid, acc_write, oe_lo, oe_hi, rd_valid;
	logic cfg_we = 1'b0;
	mmbd_cfg_sel_e cfg_sel = MMBD_CFG_DPAGE0;
	logic [2:0] cfg_space = 3'h0;
	logic [15:0] cfg_wdata = 16'h0000;
	logic [23:0] prog_counter, acc_addr;
	mmbd_target_e acc_target;
	mmbd_ext_port_s ext;
	logic [15:0] ext_data_out, ext_data_in, rd_data;
	logic [7:0] gpio_out = 8'h5A;
	logic [7:0] gpio_oe = 8'h01;
	logic [7:0] gpio_in;
	int mismatches = 0;
	int n_tests = 0;
	logic [23:0] got_t, got_a;
	logic [5:0] got_sel;
	logic [15:0] got_rd;
	logic [2:0] got_c;
	logic got_hi, got_lo;
	logic [7:0] bnd [1:3] = '{8'h40, 8'h80, 8'hC0};
	logic [7:0] pages [8] = '{8'h01, 8'h3F, 8'h40, 8'h7F, 8'h80, 8'hBF, 8'hC0, 8'hFE};
	logic [2:0] b;

	always #4 clk_sys = ~clk_sys;

	mmbd_decode uut (.clk_sys(clk_sys), .rst(rst), .core_req(core_req),
		.core_ready(core_ready), .dma_req(dma_req), .dma_ready(dma_ready), .cfg_we(cfg_we),
		.cfg_sel(cfg_sel), .cfg_space(cfg_space), .cfg_wdata(cfg_wdata),
		.prog_counter(prog_counter), .acc_valid(acc_valid), .acc_target(acc_target),
		.acc_addr(acc_addr), .acc_write(acc_write), .ext(ext), .ext_data_out(ext_data_out),
		.ext_data_oe_lo(oe_lo), .ext_data_oe_hi(oe_hi), .ext_data_in(ext_data_in),
		.gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in), .rd_valid(rd_valid),
		.rd_data(rd_data));
	mmbd_ext_mem far_side (.clk_sys(clk_sys), .ext(ext), .ext_data_out(ext_data_out),
		.ext_data_in(ext_data_in));

	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Holds the request until taken, then captures the access and read data
	task automatic take(input logic is_core);
		int i;
		i = 0;
		while ((is_core ? core_ready : dma_ready) !== 1'b1 && i < 20) begin
			@(posedge clk_sys);
			#1;
			i++;
		end
		if (i == 20) begin
			mismatches++;
			print_verdict();
		end
		@(posedge clk_sys);
		#1;
		core_req.valid = 1'b0;
		dma_req.valid = 1'b0;
		got_t = 24'(acc_target);
		got_a = acc_addr;
		got_sel = {ext.bank_select_n, ext.io_space_select_n, ext.boot_space_select_n};
		got_hi = oe_hi;
		got_lo = oe_lo;
		got_c = ext.ctrl.rd_wait;
		@(posedge clk_sys);
		#1;
		got_rd = rd_data;
	endtask

	task automatic core(input mmbd_kind_e k, input logic [15:0] ptr, input logic w);
		@(posedge clk_sys);
		#1;
		core_req.kind = k;
		core_req.ptr = ptr;
		core_req.write = w;
		core_req.valid = 1'b1;
		take(1'b1);
	endtask

	task automatic dma(input logic boot, input logic [23:0] a);
		@(posedge clk_sys);
		#1;
		dma_req.boot = boot;
		dma_req.addr = a;
		dma_req.valid = 1'b1;
		take(1'b0);
	endtask

	task automatic cfg(input mmbd_cfg_sel_e s, input logic [2:0] sp, input logic [15:0] d);
		@(posedge clk_sys);
		#1;
		cfg_we = 1'b1;
		cfg_sel = s;
		cfg_space = sp;
		cfg_wdata = d;
		@(posedge clk_sys);
		#1;
		cfg_we = 1'b0;
	endtask

	function automatic logic [2:0] bank_of(input logic [7:0] pg);
		return pg >= bnd[3] ? 3'h3 : pg >= bnd[2] ? 3'h2 : pg >= bnd[1] ? 3'h1 : 3'h0;
	endfunction

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		check("pc reset", prog_counter, 24'hFFFC00);
		core_req.seq_op = MMBD_SEQ_NEXT;
		core(MMBD_K_FETCH, 16'h0000, 1'b0);
		check("first fetch", got_t, MMBD_T_ROM);
		check("pc next", prog_counter, 24'hFFFC01);
		core_req.seq_op = MMBD_SEQ_REL;
		core_req.seq_offset = 16'hFFFE;
		core(MMBD_K_FETCH, 16'h0000, 1'b0);
		check("pc rel", prog_counter, 24'hFFFBFF);
		core_req.seq_op = MMBD_SEQ_DIRECT;
		core_req.seq_target = 24'h401234;
		core(MMBD_K_FETCH, 16'h0000, 1'b0);
		check("below rom", got_t, MMBD_T_NONE);
		check("pc direct", prog_counter, 24'h401234);
		cfg(MMBD_CFG_JPAGE, 3'h0, 16'h0080);
		core_req.seq_op = MMBD_SEQ_INDIRECT;
		core(MMBD_K_FETCH, 16'h0010, 1'b0);
		check("fetch bank", got_sel, 6'h37);
		check("pc indirect", prog_counter, 24'h800010);
		for (int s = 0; s < 6; s++)
			cfg(MMBD_CFG_CTRL, 3'(s), {3'(s), 13'h1C04});
		foreach (pages[i]) begin
			cfg(MMBD_CFG_DPAGE0, 3'h0, {8'h00, pages[i]});
			core(MMBD_K_DATA, 16'h0003, 1'b0);
			b = bank_of(pages[i]);
			check("bank target", got_t, MMBD_T_BANK);
			check("bank select", got_sel, 6'(~(6'h04 << b)));
			check("bank ctrl", got_c, b);
			check("data addr", got_a, {pages[i], 16'h0003});
		end
		cfg(MMBD_CFG_DPAGE0, 3'h0, 16'h0000);
		core(MMBD_K_DATA, 16'h7FFF, 1'b0);
		check("ram low", got_t, MMBD_T_RAM0);
		core(MMBD_K_DATA, 16'h8000, 1'b0);
		check("ram high", got_t, MMBD_T_RAM1);
		check("ram no select", got_sel, 6'h3F);
		cfg(MMBD_CFG_DPAGE0, 3'h0, 16'h00FF);
		core(MMBD_K_DATA, 16'hFC00, 1'b0);
		check("rom", got_t, MMBD_T_ROM);
		cfg(MMBD_CFG_DPAGE1, 3'h0, 16'h0080);
		core_req.address_generator = 1'b1;
		core(MMBD_K_DATA, 16'h0002, 1'b0);
		check("second page reg", got_a, 24'h800002);
		core_req.address_generator = 1'b0;
		cfg(MMBD_CFG_BOUND1, 3'h0, 16'h0020);
		bnd[1] = 8'h20;
		cfg(MMBD_CFG_DPAGE0, 3'h0, 16'h0030);
		core(MMBD_K_DATA, 16'h0000, 1'b0);
		check("moved bound", got_sel, 6'h37);
		cfg(MMBD_CFG_DPAGE0, 3'h0, 16'h0040);
		core_req.wdata = 16'hA5C3;
		core(MMBD_K_DATA, 16'h0005, 1'b1);
		check("write low oe", got_lo, 1'b1);
		core(MMBD_K_DATA, 16'h0005, 1'b0);
		check("read back", got_rd, 16'hA5C3);
		check("wide upper oe", got_hi, 1'b0);
		cfg(MMBD_CFG_CTRL, 3'h1, 16'h3C00);
		core(MMBD_K_DATA, 16'h0005, 1'b0);
		check("narrow read", got_rd, 16'h00C3);
		check("gpio upper oe", got_hi, 1'b1);
		check("gpio in", gpio_in, 8'hA5);
		cfg(MMBD_CFG_IOPAGE, 3'h0, 16'h001F);
		core_req.imm10 = 10'h3FF;
		core(MMBD_K_IO, 16'h0000, 1'b0);
		check("io inside", got_t, MMBD_T_IO_INT);
		check("io addr", got_a, 24'h007FFF);
		cfg(MMBD_CFG_IOPAGE, 3'h0, 16'h0020);
		core_req.imm10 = 10'h000;
		core(MMBD_K_IO, 16'h0000, 1'b0);
		check("io select", got_sel, 6'h3D);
		check("io ctrl", got_c, 3'h4);
		cfg(MMBD_CFG_DPAGE0, 3'h0, 16'h00C0);
		core(MMBD_K_BOOT, 16'h0001, 1'b0);
		check("boot select", got_sel, 6'h3E);
		check("boot ctrl", got_c, 3'h5);
		dma(1'b1, 24'h050000);
		check("dma boot", got_sel, 6'h3E);
		dma(1'b0, 24'hC10000);
		check("dma bank", got_sel, 6'h1F);
		print_verdict();
	end
endmodule

bind mmbd_decode mmbd_decode_properties chk (.clk_sys(clk_sys), .rst(rst),
	.core_req(core_req), .core_ready(core_ready), .dma_ready(dma_ready),
	.prog_counter(prog_counter), .acc_valid(acc_valid), .acc_target(acc_target),
	.acc_addr(acc_addr), .acc_write(acc_write), .ext(ext), .rd_valid(rd_valid));
